// ### rtl/dse_dec_alu.sv
// Byte decrement datapath with arithmetic flags
// Assumes the caller registers the result and flags
`timescale 1ns/100ps
`include "dse_defs.svh"

module dse_dec_alu (
   // Operand
   input wire dse_pkg::dse_byte_t operand_i,
   // Result
   output dse_pkg::dse_byte_t result_o,
   output dse_pkg::dse_flags_t flags_o
);

   logic [8:0] sum;
   logic [4:0] low_sum;

   // Subtracting one is adding all ones; carry means no borrow
   always_comb begin
      sum = {1'b0, operand_i} + 9'h0FF;
      low_sum = {1'b0, operand_i[3:0]} + 5'h0F;
      result_o = sum[7:0];
      flags_o = `DSE_FLAGS_RST;
      flags_o[`DSE_FLAG_C] = sum[8];
      flags_o[`DSE_FLAG_DC] = low_sum[4];
      flags_o[`DSE_FLAG_Z] = (sum[7:0] == 8'h00);
      flags_o[`DSE_FLAG_OV] = operand_i[7] & ~sum[7];
      flags_o[`DSE_FLAG_N] = sum[7];
   end

endmodule // dse_dec_alu

// ### rtl/dse_defs.svh
// Constants for the decrement / decrement-and-skip execution logic
// Assumes one core clock; four clocks make one instruction cycle
`ifndef DSE_DEFS_SVH
`define DSE_DEFS_SVH

// Opcode upper six bits
`define DSE_OP_DEC 6'h01
`define DSE_OP_DSZ 6'h0B

// Instruction field positions
`define DSE_OP_HI 15
`define DSE_OP_LO 10
`define DSE_DEST_BIT 9
`define DSE_BANK_BIT 8

// Addressing
`define DSE_IDX_MAX 8'h5F
`define DSE_ACC_SPLIT 8'h60
`define DSE_SFR_BANK 4'hF
`define DSE_LOW_BANK 4'h0

// Quarter-cycle phases
`define DSE_Q1 2'h0
`define DSE_Q2 2'h1
`define DSE_Q3 2'h2
`define DSE_Q4 2'h3

// Status flag positions
`define DSE_FLAG_C 0
`define DSE_FLAG_DC 1
`define DSE_FLAG_Z 2
`define DSE_FLAG_OV 3
`define DSE_FLAG_N 4
`define DSE_FLAGS_RST 5'h00

// Skip lengths in instruction cycles
`define DSE_SKIP_ONE 2'h1
`define DSE_SKIP_TWO 2'h2

`endif

// ### rtl/dse_exec.sv
// Execution logic for the plain decrement and decrement-and-skip ops
// Assumes the fetch unit presents one word per instruction cycle at Q1,
// data memory answers a read within the Q2 clock, and the core gives
// the bank select register and index base as steady levels.
//
// Operation
// - The plain decrement subtracts one and updates C, DC, N, OV and Z.
// - Destination bit 0 writes the working register, 1 the file register.
// - The skip decrement writes its destination and leaves all flags alone.
// - A zero skip result discards the fetched next word as an idle slot.
// - The skip decrement takes one cycle without skip and two with one.
// - Skipping a two-word instruction makes three cycles in total.
// - Bank bit 0 picks the access bank, 1 the bank select register.
// - With bank 0, extended set on and address up to 5Fh, index it.
`timescale 1ns/100ps
`include "dse_defs.svh"

module dse_exec #(
   parameter int ADDR_W = 12,
   parameter int BANK_W = 4
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Fetch side
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic next_two_word_i,
   output logic [1:0] q_phase_o,
   output logic instr_taken_o,
   output logic discard_fetch_o,
   output logic idle_slot_o,
   // Core state
   input wire logic [BANK_W-1:0] bank_select_reg_i,
   input wire logic ext_set_en_i,
   input wire logic [ADDR_W-1:0] index_base_i,
   // Data memory
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_wr_o,
   output logic [7:0] mem_wdata_o,
   // Working register and status
   output logic w_wr_o,
   output logic [7:0] w_wdata_o,
   output logic status_wr_o,
   output logic [4:0] status_flags_o
);

   if (ADDR_W != BANK_W + 8) begin : g_bad_width
      $error("dse_exec: ADDR_W must equal BANK_W + 8");
   end

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic op_is(input logic [15:0] ins,
                                  input logic [5:0] op);
      op_is = (ins[`DSE_OP_HI:`DSE_OP_LO] == op);
   endfunction

   function automatic logic [ADDR_W-1:0] eff_addr(
      input logic [7:0] f,
      input logic bank,
      input logic ext,
      input logic [BANK_W-1:0] bank_select_reg,
      input logic [ADDR_W-1:0] base);
      logic [BANK_W-1:0] acc_hi;
      acc_hi = (f < `DSE_ACC_SPLIT) ? BANK_W'(`DSE_LOW_BANK)
                                     : BANK_W'(`DSE_SFR_BANK);
      if (bank)
         eff_addr = {bank_select_reg, f};
      else if (ext && f <= `DSE_IDX_MAX)
         eff_addr = base + {{BANK_W{1'b0}}, f};
      else
         eff_addr = {acc_hi, f};
   endfunction

   // ------------------------------------------------------------
   // Quarter-cycle phase
   // ------------------------------------------------------------
   logic [1:0] q;
   logic q_last;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i)
         q <= `DSE_Q1;
      else
         q <= q + 2'h1;
   end

   assign q_last = (q == `DSE_Q4);
   assign q_phase_o = q;

   // ------------------------------------------------------------
   // Decode and sequencing
   // ------------------------------------------------------------
   dse_pkg::dse_state_e state;
   logic hit_dec;
   logic hit_dsz;
   logic take;
   logic op_dsz;
   logic dest_f;
   logic [1:0] skip_left;
   logic skip_now;
   dse_pkg::dse_byte_t operand;
   dse_pkg::dse_byte_t alu_res;
   dse_pkg::dse_flags_t alu_flags;

   assign hit_dec = op_is(instr_i, `DSE_OP_DEC);
   assign hit_dsz = op_is(instr_i, `DSE_OP_DSZ);
   assign take = (state == dse_pkg::DSE_IDLE) && (q == `DSE_Q1)
                 && instr_valid_i && (hit_dec || hit_dsz);
   assign instr_taken_o = take;
   assign idle_slot_o = (state == dse_pkg::DSE_SKIP);
   assign skip_now = op_dsz && (alu_res == 8'h00);

   // Instruction latch at Q1
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         op_dsz <= 1'b0;
         dest_f <= 1'b1;
         mem_addr_o <= '0;
      end else if (take) begin
         op_dsz <= hit_dsz;
         dest_f <= instr_i[`DSE_DEST_BIT];
         mem_addr_o <= eff_addr(instr_i[7:0], instr_i[`DSE_BANK_BIT],
                                ext_set_en_i, bank_select_reg_i,
                                index_base_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state <= dse_pkg::DSE_IDLE;
         skip_left <= 2'h0;
      end else begin
         case (state)
            dse_pkg::DSE_IDLE: begin
               if (take)
                  state <= dse_pkg::DSE_EXEC;
            end
            dse_pkg::DSE_EXEC: begin
               if (q_last && discard_fetch_o) begin
                  state <= dse_pkg::DSE_SKIP;
                  skip_left <= next_two_word_i ? `DSE_SKIP_TWO
                                               : `DSE_SKIP_ONE;
               end else if (q_last) begin
                  state <= dse_pkg::DSE_IDLE;
               end
            end
            dse_pkg::DSE_SKIP: begin
               if (q_last) begin
                  skip_left <= skip_left - 2'h1;
                  if (skip_left == `DSE_SKIP_ONE)
                     state <= dse_pkg::DSE_IDLE;
               end
            end
            default: state <= dse_pkg::DSE_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   dse_dec_alu u_alu (
      .operand_i(operand),
      .result_o(alu_res),
      .flags_o(alu_flags)
   );

   // read strobe during Q2, operand captured at its end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mem_rd_o <= 1'b0;
         operand <= 8'h00;
      end else begin
         mem_rd_o <= take;
         if (mem_rd_o)
            operand <= mem_rdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mem_wr_o <= 1'b0;
         w_wr_o <= 1'b0;
         status_wr_o <= 1'b0;
         discard_fetch_o <= 1'b0;
         mem_wdata_o <= 8'h00;
         w_wdata_o <= 8'h00;
         status_flags_o <= `DSE_FLAGS_RST;
      end else if (state == dse_pkg::DSE_EXEC && q == `DSE_Q3) begin
         mem_wr_o <= dest_f;
         w_wr_o <= ~dest_f;
         status_wr_o <= ~op_dsz;
         discard_fetch_o <= skip_now;
         mem_wdata_o <= alu_res;
         w_wdata_o <= alu_res;
         status_flags_o <= alu_flags;
      end else begin
         mem_wr_o <= 1'b0;
         w_wr_o <= 1'b0;
         status_wr_o <= 1'b0;
         discard_fetch_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_dec_flag_write: assert property (
      (state == dse_pkg::DSE_EXEC && q == `DSE_Q3 && !op_dsz)
      |=> status_wr_o && status_flags_o[`DSE_FLAG_Z] ==
          (mem_wdata_o == 8'h00) && status_flags_o[`DSE_FLAG_N] ==
          mem_wdata_o[7])
      else $error("decrement did not update flags");

   a_dest_select: assert property (
      (mem_wr_o || w_wr_o) |-> (mem_wr_o == dest_f) && (w_wr_o != mem_wr_o))
      else $error("wrong destination written");

   a_dsz_flags_kept: assert property (
      op_dsz && state != dse_pkg::DSE_IDLE |-> !status_wr_o)
      else $error("skip decrement touched flags");

   a_skip_on_zero: assert property (
      (state == dse_pkg::DSE_EXEC && q == `DSE_Q3)
      |=> discard_fetch_o == (op_dsz && mem_wdata_o == 8'h00))
      else $error("skip decision wrong");

   a_skip_one_slot: assert property (
      (discard_fetch_o && !next_two_word_i)
      |=> idle_slot_o [*4] ##1 !idle_slot_o)
      else $error("single skip not one cycle");

   a_no_skip_slot: assert property (
      (state == dse_pkg::DSE_EXEC && q_last && !discard_fetch_o)
      |=> !idle_slot_o)
      else $error("idle slot without skip");

   a_skip_two_slots: assert property (
      (discard_fetch_o && next_two_word_i)
      |=> idle_slot_o [*8] ##1 !idle_slot_o)
      else $error("two-word skip not two cycles");

   a_bank_address: assert property (
      (take && instr_i[`DSE_BANK_BIT])
      |=> mem_addr_o == {$past(bank_select_reg_i), $past(instr_i[7:0])})
      else $error("banked address wrong");

   a_index_address: assert property (
      (take && !instr_i[`DSE_BANK_BIT] && ext_set_en_i
       && instr_i[7:0] <= `DSE_IDX_MAX)
      |=> mem_addr_o == $past(index_base_i) + {{BANK_W{1'b0}},
                                              $past(instr_i[7:0])})
      else $error("indexed address wrong");

   a_quarter_order: assert property (
      take |=> mem_rd_o && q == `DSE_Q2 ##2 (mem_wr_o || w_wr_o)
      && q == `DSE_Q4)
      else $error("quarter sequence wrong");

endmodule // dse_exec

// ### rtl/dse_pkg.sv
// Types for the decrement / decrement-and-skip execution logic
// Assumes dse_defs.svh carries all numeric constants
package dse_pkg;

   typedef enum logic [1:0] {
      DSE_IDLE = 2'b00,
      DSE_EXEC = 2'b01,
      DSE_SKIP = 2'b10
   } dse_state_e;

   typedef logic [7:0] dse_byte_t;
   typedef logic [4:0] dse_flags_t;

endpackage

// ### tb/dse_mem_model.sv
// Data memory partner for the decrement execution logic
// Assumes reads are answered within the clock of the read strobe
`timescale 1ns/100ps

module dse_mem_model (
   // Clock
   input wire logic sys_clk_i,
   // Access
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem [0:4095];
   logic [7:0] last = 8'h00;

   // Outside a read the bus shows the inverse of the last answer
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;

   always @(posedge sys_clk_i) begin
      if (mem_rd_i) last <= mem[mem_addr_i];
      if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
   end
endmodule // dse_mem_model

// ### tb/test_decrement_skip_exec.sv
// Self-checking bench for the decrement execution logic
// Assumes dse_exec with its default widths and the memory model
`timescale 1ns/100ps

module test_decrement_skip_exec;
   logic sys_clk_i, sys_rst_i, instr_valid_i, next_two_word_i;
   logic ext_set_en_i, instr_taken_o, discard_fetch_o, idle_slot_o;
   logic mem_rd_o, mem_wr_o, w_wr_o, status_wr_o;
   logic [15:0] instr_i;
   logic [3:0] bank_select_reg_i;
   logic [11:0] index_base_i, mem_addr_o;
   logic [1:0] q_phase_o;
   logic [7:0] mem_rdata_i, mem_wdata_o, w_wdata_o;
   logic [4:0] status_flags_o;
   int errors, n_tests;

   dse_exec uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .next_two_word_i(next_two_word_i), .q_phase_o(q_phase_o),
      .instr_taken_o(instr_taken_o), .discard_fetch_o(discard_fetch_o),
      .idle_slot_o(idle_slot_o), .bank_select_reg_i(bank_select_reg_i),
      .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o), .w_wr_o(w_wr_o), .w_wdata_o(w_wdata_o),
      .status_wr_o(status_wr_o), .status_flags_o(status_flags_o));

   dse_mem_model part (.sys_clk_i(sys_clk_i), .mem_addr_i(mem_addr_o),
      .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
      .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // One decrement instruction, judged from take to idle slots
   // ------------------------------------------------------------
   task wait_q4;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1 n++;
      end while (q_phase_o !== 2'h3 && n < 8);
      if (n == 8) begin
         errors++;
         finish_test;
      end
   endtask

   task op(input logic [15:0] w, input logic [7:0] v, input logic two,
           input logic ext, input logic [11:0] ea);
      logic [7:0] r;
      logic [4:0] fl;
      logic pl, sk;
      int idle;
      r = v - 8'h01;
      pl = (w[15:10] === 6'h01);
      sk = !pl && (r == 8'h00);
      fl = {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
      part.mem[ea] = v;
      wait_q4;
      @(posedge sys_clk_i);
      instr_i <= w;
      instr_valid_i <= 1'b1;
      next_two_word_i <= two;
      ext_set_en_i <= ext;
      #1 chk("taken", 16'h0001, instr_taken_o);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      #1 chk("rd", 16'h0001, mem_rd_o);
      chk("addr", ea, mem_addr_o);
      repeat (2) @(posedge sys_clk_i);
      #1 chk("mem_wr", w[9], mem_wr_o);
      chk("w_wr", !w[9], w_wr_o);
      chk("data", r, w[9] ? mem_wdata_o : w_wdata_o);
      chk("st_wr", pl, status_wr_o);
      if (pl) chk("flags", {11'h000, fl}, status_flags_o);
      chk("discard", sk, discard_fetch_o);
      idle = 0;
      repeat (12) begin
         @(posedge sys_clk_i);
         #1 idle += (idle_slot_o === 1'b1);
      end
      chk("idle", sk ? (two ? 16'h8 : 16'h4) : 16'h0, 16'(idle));
      if (w[9]) chk("file", r, part.mem[ea]);
   endtask

   // ------------------------------------------------------------
   // Foreign opcode and a word outside Q1 are both ignored
   // ------------------------------------------------------------
   task refuse;
      wait_q4;
      @(posedge sys_clk_i);
      instr_i <= 16'h4E20;
      instr_valid_i <= 1'b1;
      #1 chk("foreign", 16'h0000, instr_taken_o);
      @(posedge sys_clk_i);
      instr_i <= 16'h0610;
      #1 chk("late", 16'h0000, instr_taken_o);
      chk("no_rd", 16'h0000, mem_rd_o);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      #1 chk("no_rd2", 16'h0000, mem_rd_o);
   endtask

   // ------------------------------------------------------------
   // Reset in the middle of a two-word skip
   // ------------------------------------------------------------
   task rst_mid;
      part.mem[12'h021] = 8'h01;
      wait_q4;
      @(posedge sys_clk_i);
      instr_i <= 16'h2E21;
      instr_valid_i <= 1'b1;
      next_two_word_i <= 1'b1;
      ext_set_en_i <= 1'b0;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1 chk("skipping", 16'h0001, idle_slot_o);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1 chk("rst_q", 16'h0000, q_phase_o);
      chk("rst_idle", 16'h0000, idle_slot_o);
      chk("rst_addr", 16'h0000, mem_addr_o);
      chk("rst_flags", 16'h0000, status_flags_o);
      @(posedge sys_clk_i);
      #1 chk("rel_q", 16'h0001, q_phase_o);
      chk("rel_idle", 16'h0000, idle_slot_o);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      errors = 0;
      n_tests = 0;
      sys_rst_i = 1'b1;
      instr_valid_i = 1'b0;
      instr_i = 16'h0000;
      next_two_word_i = 1'b0;
      ext_set_en_i = 1'b0;
      bank_select_reg_i = 4'h3;
      index_base_i = 12'h200;
      repeat (3) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      op(16'h0610, 8'h01, 1'b0, 1'b0, 12'h010);
      op(16'h0545, 8'h00, 1'b0, 1'b0, 12'h345);
      op(16'h06A0, 8'h80, 1'b0, 1'b0, 12'hFA0);
      op(16'h065F, 8'h10, 1'b0, 1'b1, 12'h25F);
      op(16'h0660, 8'h3C, 1'b0, 1'b1, 12'hF60);
      op(16'h2E20, 8'h05, 1'b1, 1'b0, 12'h020);
      op(16'h2E21, 8'h01, 1'b0, 1'b0, 12'h021);
      op(16'h2C22, 8'h01, 1'b1, 1'b0, 12'h022);
      op(16'h2F30, 8'h01, 1'b1, 1'b0, 12'h330);
      refuse;
      rst_mid;
      op(16'h2E21, 8'h02, 1'b0, 1'b0, 12'h021);
      finish_test;
   end
endmodule // test_decrement_skip_exec
